// [logic/nand_host_map.svh]
// Constants for the NAND host sequencer: command codes, address layout, timing.
// Assumes a 100 MHz core clock; included by bare name from the design files.
`ifndef NAND_HOST_MAP_SVH
`define NAND_HOST_MAP_SVH

// ************************************************
// Command codes
// ************************************************
`define NH_CMD_READ 8'h00
`define NH_CMD_READ_CONF 8'h30
`define NH_CMD_COPY_READ_CONF 8'h35
`define NH_CMD_PROG 8'h80
`define NH_CMD_PROG_CONF 8'h10
`define NH_CMD_COPY_PROG 8'h85
`define NH_CMD_RAND_IN `NH_CMD_COPY_PROG
`define NH_CMD_ERASE 8'h60
`define NH_CMD_ERASE_CONF 8'hd0
`define NH_CMD_RESET 8'hff
`define NH_CMD_STATUS 8'h70
`define NH_CMD_STATUS_ENH 8'h78
`define NH_CMD_READ_ID 8'h90
`define NH_CMD_PARAM 8'hec
`define NH_CMD_UID 8'hed
`define NH_CMD_RAND_OUT 8'h05
`define NH_CMD_RAND_OUT_CONF 8'he0

// ************************************************
// Status byte and geometry
// ************************************************
`define NH_STAT_FAIL_BIT 0
`define NH_STAT_READY_BIT 6
`define NH_PAGE_BYTES 13'h1100
`define NH_PAGES_PER_BLOCK 64
`define NH_BLOCKS_PER_DIE 2048
`define NH_DIE_SEL_BIT 30
`define NH_FULL_ADDR_CYCLES 3'h5
`define NH_COL_CYCLES 3'h2
`define NH_ROW_CYCLES 3'h3
`define NH_IDX_COL 3'h0
`define NH_IDX_ROW 3'h2
`define NH_IDX_ZERO 3'h5

// ************************************************
// Timing
// ************************************************
`define NH_CLK_PERIOD_NS 10
`define NH_STROBE_NS 30
`define NH_WB_NS 100
`define NH_FAST_READ_LIMIT_NS 30
`define NH_PH_CYC ((`NH_STROBE_NS + `NH_CLK_PERIOD_NS - 1) / `NH_CLK_PERIOD_NS)
`define NH_WB_CYC ((`NH_WB_NS + `NH_CLK_PERIOD_NS - 1) / `NH_CLK_PERIOD_NS)

`endif

// [logic/nand_host_pkg.sv]
// Types shared by the NAND host sequencer and its address formatter.
// Assumes nothing beyond the map header for numeric constants.
package nand_host_pkg;

  typedef enum logic [7:0]
  {
    S_IDLE = 8'h01,
    S_CMD1 = 8'h02,
    S_ADDR = 8'h04,
    S_DATW = 8'h08,
    S_CMD2 = 8'h10,
    S_WAIT = 8'h20,
    S_DATR = 8'h40,
    S_DONE = 8'h80
  } state_t;

  typedef enum logic [3:0]
  {
    PH_LOAD = 4'h1,
    PH_SETUP = 4'h2,
    PH_LOW = 4'h4,
    PH_HOLD = 4'h8
  } phase_t;

  typedef enum logic [3:0]
  {
    OP_PAGE_READ = 4'h0,
    OP_COPY_READ = 4'h1,
    OP_PROGRAM = 4'h2,
    OP_COPY_PROG = 4'h3,
    OP_ERASE = 4'h4,
    OP_RESET = 4'h5,
    OP_STATUS = 4'h6,
    OP_STATUS_ENH = 4'h7,
    OP_READ_ID = 4'h8,
    OP_PARAM = 4'h9,
    OP_UID = 4'ha,
    OP_RAND_OUT = 4'hb,
    OP_RAND_IN = 4'hc
  } op_t;

  typedef struct packed
  {
    logic [30:0] addr;
    logic [7:0] byte_q;
  } fmt_t;

  typedef struct packed
  {
    state_t st;
    phase_t ph;
    logic [7:0] tmr;
    logic [12:0] n;
    logic [2:0] aidx;
    logic [2:0] aleft;
    logic [7:0] c1;
    logic [7:0] c2;
    logic c2v;
    logic wdat;
    logic wt;
    logic rd;
    logic stat_pend;
    logic chk;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] io_out;
    logic io_oe;
    logic cmd_ready;
    logic wr_ready;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
    logic fail;
    logic err;
  } ctl_t;

endpackage

// [logic/addr_cycle_fmt.sv]
// Holds the latched flash address and serves one address-cycle byte per index.
// Assumes the index is stable one cycle before the byte is used.
`include "nand_host_map.svh"

module addr_cycle_fmt
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [30:0] addr,
  input wire logic [2:0] idx,
  output logic [7:0] addr_byte
);
  import nand_host_pkg::*;

  fmt_t fmt_ff;
  fmt_t nxt_fmt;

  function automatic logic [7:0] byte_of(input logic [30:0] a, input logic [2:0] i);
    case (i)
      3'h0: byte_of = a[7:0];
      3'h1: byte_of = {3'h0, a[12:8]};
      3'h2: byte_of = a[20:13];
      3'h3: byte_of = a[28:21];
      3'h4: byte_of = {6'h00, a[30:29]};
      default: byte_of = 8'h00;
    endcase
  endfunction

  always_comb
  begin
    nxt_fmt = fmt_ff;
    if (load)
    begin
      nxt_fmt.addr = addr;
    end
    nxt_fmt.byte_q = byte_of(fmt_ff.addr, idx);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fmt_ff <= '0;
    end
    else if (clk_en)
    begin
      fmt_ff <= nxt_fmt;
    end
  end

  assign addr_byte = fmt_ff.byte_q;

endmodule

// [logic/nand_host.sv]
// NAND flash host sequencer: turns one operation request into pin cycles.
// Assumes the flash pins are sampled synchronously and io wires are resolved outside.
`include "nand_host_map.svh"

module nand_host
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire nand_host_pkg::op_t cmd_op,
  input wire logic [30:0] cmd_addr,
  input wire logic [12:0] cmd_len,
  input wire logic allow_modify,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_fail,
  output logic cmd_error,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic rb_n
);
  import nand_host_pkg::*;

  localparam logic [7:0] PH_LAST = 8'(`NH_PH_CYC - 1);
  localparam logic [7:0] WB_LAST = 8'(`NH_WB_CYC - 1);

  ctl_t ctl_ff;
  ctl_t nxt_ctl;
  logic addr_load;
  logic [7:0] addr_byte;

  // Next bus step once the current one has finished; fixed command order
  function automatic state_t pick(input logic w, input logic c2v, input logic wt, input logic rd);
    if (w) pick = S_DATW;
    else if (c2v) pick = S_CMD2;
    else if (wt) pick = S_WAIT;
    else if (rd) pick = S_DATR;
    else pick = S_DONE;
  endfunction

  addr_cycle_fmt u_addr_cycle_fmt
  (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .load(addr_load),
    .addr(cmd_addr),
    .idx(ctl_ff.aidx),
    .addr_byte(addr_byte)
  );

  // ************************************************
  // Sequencer
  // ************************************************
  always_comb
  begin
    logic bad;
    logic [2:0] na;
    logic [2:0] ai;
    bad = 1'b0;
    na = 3'h0;
    ai = `NH_IDX_COL;
    nxt_ctl = ctl_ff;
    addr_load = 1'b0;
    nxt_ctl.wr_ready = 1'b0;
    nxt_ctl.rd_valid = 1'b0;
    nxt_ctl.done = 1'b0;
    nxt_ctl.err = 1'b0;
    case (ctl_ff.st)
      S_IDLE:
      begin
        nxt_ctl.cmd_ready = 1'b1;
        nxt_ctl.ce_n = 1'b1;
        nxt_ctl.wp_n = allow_modify;
        if (cmd_valid && ctl_ff.cmd_ready)
        begin
          nxt_ctl.c2v = 1'b0;
          nxt_ctl.wdat = 1'b0;
          nxt_ctl.wt = 1'b0;
          nxt_ctl.rd = cmd_len != 13'h0000;
          nxt_ctl.stat_pend = 1'b0;
          nxt_ctl.n = cmd_len;
          // Only defined codes can leave this decode
          case (cmd_op)
            OP_PAGE_READ, OP_COPY_READ:
            begin
              nxt_ctl.c1 = `NH_CMD_READ;
              na = `NH_FULL_ADDR_CYCLES;
              nxt_ctl.c2 = (cmd_op == OP_PAGE_READ) ? `NH_CMD_READ_CONF : `NH_CMD_COPY_READ_CONF;
              nxt_ctl.c2v = 1'b1;
              nxt_ctl.wt = 1'b1;
              nxt_ctl.rd = (cmd_op == OP_PAGE_READ) && (cmd_len != 13'h0000);
            end
            OP_PROGRAM, OP_COPY_PROG:
            begin
              nxt_ctl.c1 = (cmd_op == OP_PROGRAM) ? `NH_CMD_PROG : `NH_CMD_COPY_PROG;
              na = `NH_FULL_ADDR_CYCLES;
              nxt_ctl.wdat = cmd_len != 13'h0000;
              nxt_ctl.rd = 1'b0;
              nxt_ctl.c2 = `NH_CMD_PROG_CONF;
              nxt_ctl.c2v = 1'b1;
              nxt_ctl.wt = 1'b1;
              nxt_ctl.stat_pend = 1'b1;
              // Plain program with no data would be a silent no-op
              bad = !allow_modify || (cmd_op == OP_PROGRAM && cmd_len == 13'h0000);
            end
            OP_ERASE:
            begin
              nxt_ctl.c1 = `NH_CMD_ERASE;
              na = `NH_ROW_CYCLES;
              ai = `NH_IDX_ROW;
              nxt_ctl.rd = 1'b0;
              nxt_ctl.c2 = `NH_CMD_ERASE_CONF;
              nxt_ctl.c2v = 1'b1;
              nxt_ctl.wt = 1'b1;
              nxt_ctl.stat_pend = 1'b1;
              bad = !allow_modify;
            end
            OP_RESET:
            begin
              nxt_ctl.c1 = `NH_CMD_RESET;
              nxt_ctl.rd = 1'b0;
              nxt_ctl.wt = 1'b1;
            end
            OP_STATUS, OP_STATUS_ENH:
            begin
              nxt_ctl.c1 = (cmd_op == OP_STATUS) ? `NH_CMD_STATUS : `NH_CMD_STATUS_ENH;
              na = (cmd_op == OP_STATUS) ? 3'h0 : `NH_ROW_CYCLES;
              ai = `NH_IDX_ROW;
              nxt_ctl.rd = 1'b1;
              nxt_ctl.n = 13'h0001;
            end
            OP_READ_ID, OP_PARAM, OP_UID:
            begin
              nxt_ctl.c1 = (cmd_op == OP_READ_ID) ? `NH_CMD_READ_ID :
                (cmd_op == OP_PARAM) ? `NH_CMD_PARAM : `NH_CMD_UID;
              na = 3'h1;
              ai = `NH_IDX_ZERO;
              nxt_ctl.wt = cmd_op != OP_READ_ID;
            end
            OP_RAND_OUT:
            begin
              nxt_ctl.c1 = `NH_CMD_RAND_OUT;
              na = `NH_COL_CYCLES;
              nxt_ctl.c2 = `NH_CMD_RAND_OUT_CONF;
              nxt_ctl.c2v = 1'b1;
            end
            OP_RAND_IN:
            begin
              nxt_ctl.c1 = `NH_CMD_RAND_IN;
              na = `NH_COL_CYCLES;
              nxt_ctl.wdat = cmd_len != 13'h0000;
              nxt_ctl.rd = 1'b0;
              bad = !allow_modify;
            end
            default: bad = 1'b1;
          endcase
          // A transfer is never longer than one page; the start column is not checked
          if (cmd_len > `NH_PAGE_BYTES)
          begin
            bad = 1'b1;
          end
          if (bad)
          begin
            nxt_ctl.err = 1'b1;
          end
          else
          begin
            addr_load = 1'b1;
            nxt_ctl.cmd_ready = 1'b0;
            nxt_ctl.ce_n = 1'b0;
            nxt_ctl.fail = 1'b0;
            nxt_ctl.chk = 1'b0;
            nxt_ctl.aleft = na;
            nxt_ctl.aidx = ai;
            nxt_ctl.st = S_CMD1;
            nxt_ctl.ph = PH_LOAD;
          end
        end
      end
      S_CMD1, S_ADDR, S_DATW, S_CMD2, S_DATR:
      begin
        case (ctl_ff.ph)
          PH_LOAD:
          begin
            nxt_ctl.cle = ctl_ff.st == S_CMD1 || ctl_ff.st == S_CMD2;
            nxt_ctl.ale = ctl_ff.st == S_ADDR;
            nxt_ctl.io_oe = ctl_ff.st != S_DATR;
            nxt_ctl.io_out = (ctl_ff.st == S_CMD1) ? ctl_ff.c1 :
              (ctl_ff.st == S_CMD2) ? ctl_ff.c2 :
              (ctl_ff.st == S_ADDR) ? addr_byte : ctl_ff.io_out;
            // Data phase stalls here until the source offers a byte
            if (ctl_ff.st != S_DATW || wr_valid)
            begin
              nxt_ctl.ph = PH_SETUP;
              nxt_ctl.tmr = PH_LAST;
              if (ctl_ff.st == S_DATW)
              begin
                nxt_ctl.io_out = wr_data;
                nxt_ctl.wr_ready = 1'b1;
              end
            end
          end
          PH_SETUP:
          begin
            if (ctl_ff.tmr != 8'h00)
            begin
              nxt_ctl.tmr = ctl_ff.tmr - 8'h01;
            end
            else
            begin
              nxt_ctl.ph = PH_LOW;
              nxt_ctl.tmr = PH_LAST;
              if (ctl_ff.st == S_DATR)
              begin
                nxt_ctl.re_n = 1'b0;
              end
              else
              begin
                nxt_ctl.we_n = 1'b0;
              end
            end
          end
          PH_LOW:
          begin
            if (ctl_ff.tmr != 8'h00)
            begin
              nxt_ctl.tmr = ctl_ff.tmr - 8'h01;
            end
            else
            begin
              nxt_ctl.ph = PH_HOLD;
              nxt_ctl.tmr = PH_LAST;
              nxt_ctl.we_n = 1'b1;
              nxt_ctl.re_n = 1'b1;
              // Bumped early so the formatter byte settles before the next load
              if (ctl_ff.st == S_ADDR)
              begin
                nxt_ctl.aidx = ctl_ff.aidx + 3'h1;
              end
              // Cycle is well above the fast-read limit, so sample before rise
              if (ctl_ff.st == S_DATR)
              begin
                nxt_ctl.rd_data = io_in;
                nxt_ctl.rd_valid = 1'b1;
                if (ctl_ff.chk)
                begin
                  nxt_ctl.fail = io_in[`NH_STAT_FAIL_BIT];
                end
              end
            end
          end
          PH_HOLD:
          begin
            if (ctl_ff.tmr != 8'h00)
            begin
              nxt_ctl.tmr = ctl_ff.tmr - 8'h01;
            end
            else
            begin
              nxt_ctl.ph = PH_LOAD;
              case (ctl_ff.st)
                S_CMD1:
                  nxt_ctl.st = (ctl_ff.aleft != 3'h0) ? S_ADDR : pick(ctl_ff.wdat, ctl_ff.c2v, ctl_ff.wt, ctl_ff.rd);
                S_ADDR:
                begin
                  nxt_ctl.aleft = ctl_ff.aleft - 3'h1;
                  if (ctl_ff.aleft == 3'h1)
                  begin
                    nxt_ctl.st = pick(ctl_ff.wdat, ctl_ff.c2v, ctl_ff.wt, ctl_ff.rd);
                  end
                end
                S_DATW:
                begin
                  nxt_ctl.n = ctl_ff.n - 13'h0001;
                  if (ctl_ff.n == 13'h0001)
                  begin
                    nxt_ctl.st = pick(1'b0, ctl_ff.c2v, ctl_ff.wt, ctl_ff.rd);
                  end
                end
                S_CMD2:
                  nxt_ctl.st = pick(1'b0, 1'b0, ctl_ff.wt, ctl_ff.rd);
                S_DATR:
                begin
                  nxt_ctl.n = ctl_ff.n - 13'h0001;
                  if (ctl_ff.n == 13'h0001)
                  begin
                    nxt_ctl.st = S_DONE;
                  end
                end
                default: nxt_ctl.st = S_DONE;
              endcase
              nxt_ctl.cle = 1'b0;
              nxt_ctl.ale = 1'b0;
              nxt_ctl.tmr = WB_LAST;
            end
          end
          default: nxt_ctl.ph = PH_LOAD;
        endcase
      end
      S_WAIT:
      begin
        nxt_ctl.io_oe = 1'b0;
        // Busy shows up only after a short delay, so ready is ignored until then
        if (ctl_ff.tmr != 8'h00)
        begin
          nxt_ctl.tmr = ctl_ff.tmr - 8'h01;
        end
        else if (rb_n)
        begin
          nxt_ctl.ph = PH_LOAD;
          if (ctl_ff.stat_pend)
          begin
            nxt_ctl.c1 = `NH_CMD_STATUS;
            nxt_ctl.aleft = 3'h0;
            nxt_ctl.c2v = 1'b0;
            nxt_ctl.wdat = 1'b0;
            nxt_ctl.wt = 1'b0;
            nxt_ctl.rd = 1'b1;
            nxt_ctl.n = 13'h0001;
            nxt_ctl.chk = 1'b1;
            nxt_ctl.stat_pend = 1'b0;
            nxt_ctl.st = S_CMD1;
          end
          else
          begin
            nxt_ctl.st = pick(1'b0, 1'b0, 1'b0, ctl_ff.rd);
          end
        end
      end
      S_DONE:
      begin
        nxt_ctl.done = 1'b1;
        nxt_ctl.ce_n = 1'b1;
        nxt_ctl.io_oe = 1'b0;
        nxt_ctl.chk = 1'b0;
        nxt_ctl.cmd_ready = 1'b1;
        nxt_ctl.st = S_IDLE;
      end
      default: nxt_ctl.st = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctl_ff <= '0;
      ctl_ff.st <= S_IDLE;
      ctl_ff.ph <= PH_LOAD;
      ctl_ff.ce_n <= 1'b1;
      ctl_ff.we_n <= 1'b1;
      ctl_ff.re_n <= 1'b1;
    end
    else if (clk_en)
    begin
      ctl_ff <= nxt_ctl;
    end
  end

  assign cmd_ready = ctl_ff.cmd_ready;
  assign cmd_done = ctl_ff.done;
  assign cmd_fail = ctl_ff.fail;
  assign cmd_error = ctl_ff.err;
  assign wr_ready = ctl_ff.wr_ready;
  assign rd_data = ctl_ff.rd_data;
  assign rd_valid = ctl_ff.rd_valid;
  assign ce_n = ctl_ff.ce_n;
  assign cle = ctl_ff.cle;
  assign ale = ctl_ff.ale;
  assign we_n = ctl_ff.we_n;
  assign re_n = ctl_ff.re_n;
  assign wp_n = ctl_ff.wp_n;
  assign io_out = ctl_ff.io_out;
  assign io_oe = ctl_ff.io_oe;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst || !clk_en);

  property p_cmd_latch;
    $rose(we_n) && cle |-> !ce_n && !ale && re_n && io_oe;
  endproperty
  a_cmd_latch: assert property (p_cmd_latch) else $error("command latch with bad control levels");

  property p_addr_latch;
    $rose(we_n) && ale |-> !ce_n && !cle && re_n && io_oe;
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address latch with bad control levels");

  property p_data_latch;
    $rose(we_n) && !cle && !ale |-> !ce_n && re_n && wp_n;
  endproperty
  a_data_latch: assert property (p_data_latch) else $error("data latch with bad control levels");

  property p_modify_wp;
    $rose(we_n) && cle && (io_out == `NH_CMD_PROG || io_out == `NH_CMD_ERASE || io_out == `NH_CMD_PROG_CONF ||
      io_out == `NH_CMD_ERASE_CONF || io_out == `NH_CMD_COPY_PROG) |-> wp_n;
  endproperty
  a_modify_wp: assert property (p_modify_wp) else $error("modify command sent with protect low");

  property p_col_hi;
    $rose(we_n) && ale && ctl_ff.aidx == 3'h2 |-> io_out[7:5] == 3'h0;
  endproperty
  a_col_hi: assert property (p_col_hi) else $error("second address byte has top bits set");

  property p_blk_hi;
    $rose(we_n) && ale && ctl_ff.aidx == 3'h5 && $past(ctl_ff.aleft) == 3'h1 |-> io_out[7:2] == 6'h00;
  endproperty
  a_blk_hi: assert property (p_blk_hi) else $error("fifth address byte has top bits set");

  property p_legal_code;
    $rose(we_n) && cle |-> io_out inside {`NH_CMD_READ, `NH_CMD_READ_CONF, `NH_CMD_COPY_READ_CONF,
      `NH_CMD_PROG, `NH_CMD_PROG_CONF, `NH_CMD_COPY_PROG, `NH_CMD_ERASE, `NH_CMD_ERASE_CONF, `NH_CMD_RESET,
      `NH_CMD_STATUS, `NH_CMD_STATUS_ENH, `NH_CMD_READ_ID, `NH_CMD_PARAM, `NH_CMD_UID, `NH_CMD_RAND_OUT,
      `NH_CMD_RAND_OUT_CONF};
  endproperty
  a_legal_code: assert property (p_legal_code) else $error("undefined command code sent");

  property p_rd_sample;
    rd_valid |-> $rose(re_n) && !io_oe;
  endproperty
  a_rd_sample: assert property (p_rd_sample) else $error("read byte not taken at end of strobe low");

  property p_re_low;
    $fell(re_n) |-> !re_n [*3] ##1 re_n;
  endproperty
  a_re_low: assert property (p_re_low) else $error("read strobe low time wrong");

  property p_wait_ready;
    ctl_ff.st == S_WAIT ##1 ctl_ff.st != S_WAIT |-> $past(rb_n);
  endproperty
  a_wait_ready: assert property (p_wait_ready) else $error("left busy wait while busy");

  property p_sel_held;
    ctl_ff.st != S_IDLE && ctl_ff.st != S_DONE |-> !ce_n;
  endproperty
  a_sel_held: assert property (p_sel_held) else $error("select released mid operation");

  c_read_done: cover property (ctl_ff.st == S_DATR ##[1:300] cmd_done);
  c_status_fail: cover property (cmd_done && cmd_fail);
  c_refused: cover property (cmd_error);
  c_write_stall: cover property (ctl_ff.st == S_DATW && ctl_ff.ph == PH_LOAD && !wr_valid);

endmodule

// [verification/nand_dev_model.sv]
// Behavioural flash die: latches pin cycles, serves page and status bytes.
// Assumes pins change on core_clk edges; samples them on the same clock.
module nand_dev_model
(
  input wire logic core_clk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic force_fail,
  output logic [7:0] io_in,
  output logic rb_n
);
  // ************************************************
  // Pin decode
  // ************************************************
  logic pw = 1;
  logic pr = 1;
  logic stat = 0;
  logic ndat = 0;
  logic [2:0] acnt = 0;
  logic [12:0] col = 0;
  logic [7:0] last_cmd = 0;
  logic [7:0] dout = 0;
  logic [7:0] lastv = 0;
  logic [7:0] ab [5];
  logic [7:0] wd [8];
  int bc = 0;
  int viol = 0;
  // Released bus shows the inverse, never a stale byte
  assign io_in = io_oe ? io_out : (!ce_n && !re_n) ? dout : ~lastv;
  assign rb_n = (bc == 0);
  always @(posedge core_clk)
  begin
    pw <= we_n;
    pr <= re_n;
    lastv <= io_in;
    if (bc != 0)
      bc <= bc - 1;
    if (!wp_n && last_cmd inside {8'h10, 8'hd0})
      bc <= 0;
    if (io_oe && !ce_n && !re_n)
      viol <= viol + 1;
    if (we_n && !pw && !ce_n)
    begin
      if (cle && !ale && (bc == 0 || io_out inside {8'hff, 8'h70, 8'h78}))
      begin
        last_cmd <= io_out;
        stat <= io_out inside {8'h70, 8'h78};
        acnt <= 0;
        if (io_out inside {8'h80, 8'h60, 8'h85} && !wp_n)
          viol <= viol + 1;
        if (io_out inside {8'h30, 8'h35, 8'hd0, 8'hff} || (io_out == 8'h10 && ndat))
          bc <= 20;
        if (io_out == 8'h80)
          ndat <= 0;
      end
      else if (ale && !cle)
      begin
        ab[acnt] <= io_out;
        acnt <= acnt + 1;
        if (acnt == 1)
          col <= {io_out[4:0], ab[0]};
      end
      else if (!cle && !ale && wp_n)
      begin
        wd[col[2:0]] <= io_out;
        col <= col + 1;
        ndat <= 1;
      end
    end
    if (!re_n && pr && !ce_n)
    begin
      dout <= stat ? {1'b0, bc == 0, 5'h0, force_fail} : 8'h5a ^ col[7:0];
      col <= col + 1;
    end
  end
endmodule

// [verification/test_nand_host.sv]
// Self-checking bench for the NAND host sequencer with a flash model.
// Assumes the design files and nand_dev_model are compiled first.
module test_nand_host;
  timeunit 1ns;
  timeprecision 100ps;
  import nand_host_pkg::*;
  // ************************************************
  // Signals and instances
  // ************************************************
  logic core_clk = 0, rst = 1, clk_en = 1, cmd_valid = 0, allow_modify = 1, wr_valid = 1, force_fail = 0;
  op_t cmd_op = OP_STATUS;
  logic [30:0] cmd_addr = 0;
  logic [12:0] cmd_len = 1;
  logic [7:0] wr_data = 0, rd_data, io_out, io_in;
  logic cmd_ready, cmd_done, cmd_fail, cmd_error, wr_ready, rd_valid, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_n;
  logic err_seen;
  logic [7:0] rq [$];
  logic [7:0] wbuf [2] = '{8'ha1, 8'hb2};
  int err_count = 0, check_count = 0, cyc = 0, widx = 0;
  nand_host u_nand_host (.core_clk, .rst, .clk_en, .cmd_valid, .cmd_op, .cmd_addr, .cmd_len, .allow_modify,
    .cmd_ready, .cmd_done, .cmd_fail, .cmd_error, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid,
    .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .io_out, .io_oe, .io_in, .rb_n);
  nand_dev_model u_nand_dev_model (.core_clk, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .io_out, .io_oe,
    .force_fail, .io_in, .rb_n);
  initial forever #5 core_clk = ~core_clk;
  // Write feed, read capture and hang limit
  always @(posedge core_clk)
  begin
    #1;
    if (wr_ready === 1'b1)
      widx++;
    wr_data = wbuf[widx[0]];
    if (rd_valid === 1'b1)
      rq.push_back(rd_data);
    if (++cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("FAIL %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task run(input op_t op, input logic [30:0] a, input logic [12:0] l);
    logic rdy;
    @(posedge core_clk) #1;
    cmd_op = op;
    cmd_addr = a;
    cmd_len = l;
    cmd_valid = 1;
    rdy = 0;
    while (!rdy)
    begin
      rdy = (cmd_ready === 1'b1);
      @(posedge core_clk) #1;
    end
    cmd_valid = 0;
    for (int i = 0; i < 3000 && cmd_done !== 1'b1 && cmd_error !== 1'b1; i++)
      @(posedge core_clk) #1;
    err_seen = (cmd_error === 1'b1);
    if (cmd_done !== 1'b1 && !err_seen)
      chk(8'h00, 8'h01);
  endtask
  // ************************************************
  // Scenarios
  // ************************************************
  task t_status();
    run(OP_STATUS, 0, 1);
    chk(rq.pop_back(), 8'h40);
    chk(u_nand_dev_model.last_cmd, 8'h70);
  endtask
  task t_prog();
    widx = 0;
    run(OP_PROGRAM, {12'h801, 6'h05, 13'h1f03}, 2);
    chk(u_nand_dev_model.ab[0], 8'h03);
    chk(u_nand_dev_model.ab[1], 8'h1f);
    chk(u_nand_dev_model.ab[2], 8'h45);
    chk(u_nand_dev_model.ab[3], 8'h00);
    chk(u_nand_dev_model.ab[4], 8'h02);
    chk(u_nand_dev_model.wd[3], 8'ha1);
    chk(u_nand_dev_model.wd[4], 8'hb2);
    chk({7'h0, cmd_fail}, 8'h00);
  endtask
  task t_erase();
    force_fail = 1;
    run(OP_ERASE, {12'h801, 6'h05, 13'h0}, 0);
    chk(u_nand_dev_model.ab[0], 8'h45);
    chk({7'h0, cmd_fail}, 8'h01);
    force_fail = 0;
    run(OP_RESET, 0, 0);
    chk(u_nand_dev_model.last_cmd, 8'hff);
  endtask
  task t_read();
    rq.delete();
    run(OP_PAGE_READ, 31'h2, 2);
    chk(rq[0], 8'h58);
    chk(rq[1], 8'h59);
    chk(u_nand_dev_model.last_cmd, 8'h30);
  endtask
  task t_misc();
    run(OP_READ_ID, 0, 1);
    chk(u_nand_dev_model.ab[0], 8'h00);
    chk(u_nand_dev_model.last_cmd, 8'h90);
    run(OP_STATUS_ENH, {12'h801, 6'h05, 13'h0}, 1);
    chk(u_nand_dev_model.ab[2], 8'h02);
    chk(rq.pop_back(), 8'h40);
    run(OP_RAND_OUT, 31'h10, 1);
    chk(rq.pop_back(), 8'h4a);
    chk(u_nand_dev_model.last_cmd, 8'he0);
    widx = 0;
    run(OP_RAND_IN, 31'h20, 1);
    chk(u_nand_dev_model.wd[0], 8'ha1);
    run(OP_COPY_PROG, 0, 0);
    chk(u_nand_dev_model.last_cmd, 8'h70);
    chk({7'h0, cmd_fail}, 8'h00);
    run(OP_COPY_READ, 0, 0);
    chk(u_nand_dev_model.last_cmd, 8'h35);
    run(OP_PARAM, 0, 1);
    chk(u_nand_dev_model.last_cmd, 8'hec);
    run(OP_UID, 0, 1);
    chk(u_nand_dev_model.last_cmd, 8'hed);
  endtask
  task t_refuse();
    run(op_t'(4'hd), 0, 1);
    chk({7'h0, err_seen}, 8'h01);
    run(OP_PROGRAM, 0, 0);
    chk({7'h0, err_seen}, 8'h01);
    run(OP_PAGE_READ, 0, 13'h1101);
    chk({7'h0, err_seen}, 8'h01);
    allow_modify = 0;
    run(OP_ERASE, 0, 0);
    chk({7'h0, err_seen}, 8'h01);
    allow_modify = 1;
  endtask
  task final_report();
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1 rst = 0;
    t_status();
    t_prog();
    t_erase();
    t_read();
    t_misc();
    t_refuse();
    chk(8'(u_nand_dev_model.viol), 8'h00);
    final_report();
  end
endmodule
